// ### bst_pkg.sv
// Shared constants, types and decode helpers for the boundary-scan test port
package bst_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes of the scan structures
  localparam int unsigned BST_NUM_IO  = 4;              // Scanned user I/O pins
  localparam int unsigned BST_CELLS   = 3;              // Cells per I/O: in, out, oe
  localparam int unsigned BST_BSR_LEN = BST_CELLS * BST_NUM_IO;
  localparam int unsigned BST_IR_W    = 3;
  localparam int unsigned BST_ID_W    = 32;
  localparam int unsigned BST_ST_W    = 4;

  // Cell positions within one I/O group, counted from the output end
  localparam int unsigned BST_CELL_IN  = 0;
  localparam int unsigned BST_CELL_OUT = 1;
  localparam int unsigned BST_CELL_OE  = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction codes
  localparam logic [BST_IR_W-1:0] BST_IR_EXTEST  = 3'h0;
  localparam logic [BST_IR_W-1:0] BST_IR_SAMPLE  = 3'h1;
  localparam logic [BST_IR_W-1:0] BST_IR_HIGHZ   = 3'h5;
  localparam logic [BST_IR_W-1:0] BST_IR_CLAMP   = 3'h6;
  localparam logic [BST_IR_W-1:0] BST_IR_BYPASS  = 3'h7;
  localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 3'h1;  // Fixed pattern loaded at capture

  ////////////////////////////////////////////////////////////////////////////////
  // Identification fields; the values are arbitrary
  localparam logic [3:0]  BST_ID_VERSION = 4'h1;
  localparam logic [15:0] BST_ID_PART    = 16'h0001;
  localparam logic [10:0] BST_ID_MAKER   = 11'h001;
  localparam logic [0:0]  BST_ID_LSB     = 1'h1;
  localparam logic [BST_ID_W-1:0] BST_ID_VALUE =
    {BST_ID_VERSION, BST_ID_PART, BST_ID_MAKER, BST_ID_LSB};

  ////////////////////////////////////////////////////////////////////////////////
  // Timing figures
  localparam int unsigned BST_CLK_MHZ         = 100;
  localparam int unsigned BST_TCK_MAX_MHZ     = 20;
  localparam int unsigned BST_TCK_MIN_CYC     = (BST_CLK_MHZ + BST_TCK_MAX_MHZ - 1) / BST_TCK_MAX_MHZ;
  localparam int unsigned BST_TMS_RESET_TICKS = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Controller states
  typedef enum logic [BST_ST_W-1:0] {
    TAP_TLR    = 4'hF,
    TAP_RTI    = 4'hC,
    TAP_SEL_DR = 4'h7,
    TAP_CAP_DR = 4'h6,
    TAP_SH_DR  = 4'h2,
    TAP_EX1_DR = 4'h1,
    TAP_PA_DR  = 4'h3,
    TAP_EX2_DR = 4'h0,
    TAP_UPD_DR = 4'h5,
    TAP_SEL_IR = 4'h4,
    TAP_CAP_IR = 4'hE,
    TAP_SH_IR  = 4'hA,
    TAP_EX1_IR = 4'h9,
    TAP_PA_IR  = 4'hB,
    TAP_EX2_IR = 4'h8,
    TAP_UPD_IR = 4'hD
  } bst_state_t;

  // Pin drive group: level and enable for each scanned pin
  typedef struct packed {
    logic [BST_NUM_IO-1:0] out;
    logic [BST_NUM_IO-1:0] oe;
  } bst_pins_t;

  // Decoded instruction
  typedef struct packed {
    logic sel_bsr;
    logic sel_id;
    logic drive;   // Pins follow the boundary register
    logic hiz;     // All pins released
    logic core;    // Core sees the boundary register
  } bst_dec_t;

  // Next controller state from the sampled mode-select bit
  function automatic bst_state_t bst_next(input bst_state_t st, input logic tms);
    bst_state_t n;
    n = TAP_TLR;
    case (st)
      TAP_TLR:    n = tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    n = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  n = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: n = tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  n = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_RTI;
      default:    n = TAP_TLR;
    endcase
    return n;
  endfunction : bst_next

endpackage : bst_pkg

// ### bst_bsr_chain.sv
// Boundary-scan register: capture/shift stage and registered update stage
`timescale 1ns/1ps
module bst_bsr_chain
  import bst_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   capture_en,
  input  wire logic                   shift_en,
  input  wire logic                   update_en,
  input  wire logic                   tdi,
  input  wire logic [bst_pkg::BST_BSR_LEN-1:0] par_in,
  output logic      [bst_pkg::BST_BSR_LEN-1:0] par_out,
  output logic                        so
);
  import bst_pkg::*;

  logic [BST_BSR_LEN-1:0] chain_q;
  logic [BST_BSR_LEN-1:0] upd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial stage: parallel capture, then shift from the input end toward bit 0
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chain_q <= '0;
    else if (capture_en)
      chain_q <= par_in;
    else if (shift_en)
      chain_q <= {tdi, chain_q[BST_BSR_LEN-1:1]};
  end

  // Parallel output stage holds steady while the chain shifts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      upd_q <= '0;
    else if (update_en)
      upd_q <= chain_q;
  end

  assign par_out = upd_q;
  assign so      = chain_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_bsr_shift_in: assert property (@(posedge clk) disable iff (!rst_n)
    (shift_en && !capture_en) |=> chain_q[BST_BSR_LEN-1] == $past(tdi))
    else $error("boundary chain did not take serial input");

  chk_bsr_update_hold: assert property (@(posedge clk) disable iff (!rst_n)
    update_en |=> (upd_q == $past(chain_q)) ##1 (!update_en || upd_q == $past(chain_q, 2)))
    else $error("boundary update stage wrong");

endmodule : bst_bsr_chain

// ### bst_tap.sv
// Boundary-scan test port: controller, instruction register, data registers, pin muxing
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output logic                             tdo,
  output logic                             tdo_oe,
  input  wire bst_pkg::bst_pins_t          core_drive,
  input  wire logic [bst_pkg::BST_NUM_IO-1:0] pad_in,
  output bst_pkg::bst_pins_t               pad_drive,
  output logic [bst_pkg::BST_NUM_IO-1:0]   core_in
);
  import bst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0]            tck_sync_q;    // Two sync stages plus edge history
  logic [1:0]            tms_sync_q;
  logic [1:0]            tdi_sync_q;
  logic [BST_NUM_IO-1:0] pad_meta_q;
  logic [BST_NUM_IO-1:0] pad_sync_q;
  logic                  tck_rise;
  logic                  tck_fall;
  logic                  tms_s;
  logic                  tdi_s;
  bst_state_t            state_q;
  logic [BST_IR_W-1:0]   ir_q;
  logic [BST_IR_W-1:0]   ir_sr_q;
  logic                  id_sel_q;
  logic                  byp_q;
  logic [BST_ID_W-1:0]   id_sr_q;
  bst_dec_t              dec;
  logic                  in_shift;
  logic                  dr_bit;
  logic                  bsr_so;
  logic [BST_BSR_LEN-1:0] bsr_par_in;
  logic [BST_BSR_LEN-1:0] bsr_par_out;
  logic [BST_NUM_IO-1:0] bsr_out;
  logic [BST_NUM_IO-1:0] bsr_oe;
  logic [BST_NUM_IO-1:0] bsr_in;
  logic                  tdo_q;
  logic                  tdo_oe_q;
  bst_pins_t             pad_q;
  logic [BST_NUM_IO-1:0] core_in_q;

  // Instruction decode; unlisted codes fall through to bypass
  function automatic bst_dec_t bst_decode(input logic [BST_IR_W-1:0] ir, input logic id_sel);
    bst_dec_t d;
    d = '0;
    case (ir)
      BST_IR_EXTEST:
      begin
        d.sel_bsr = 1'b1;
        d.drive   = 1'b1;
        d.core    = 1'b1;
      end
      BST_IR_SAMPLE: d.sel_bsr = 1'b1;
      BST_IR_HIGHZ:  d.hiz     = 1'b1;
      BST_IR_CLAMP:  d.drive   = 1'b1;
      BST_IR_BYPASS: d.sel_id  = id_sel;
      default:       d.sel_id  = 1'b0;
    endcase
    return d;
  endfunction : bst_decode

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds logic, plus the third test clock stage for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tck_sync_q <= '0;
      tms_sync_q <= '1;
      tdi_sync_q <= '1;
      pad_meta_q <= '0;
      pad_sync_q <= '0;
    end
    else
    begin
      tck_sync_q <= {tck_sync_q[1:0], tck};
      tms_sync_q <= {tms_sync_q[0], tms};
      tdi_sync_q <= {tdi_sync_q[0], tdi};
      pad_meta_q <= pad_in;
      pad_sync_q <= pad_meta_q;
    end
  end

  // Test clock edges seen from the system clock
  assign tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
  assign tck_fall = ~tck_sync_q[1] & tck_sync_q[2];
  assign tms_s    = tms_sync_q[1];
  assign tdi_s    = tdi_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Controller state, stepped at each test clock rise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= TAP_TLR;
    else if (tck_rise)
      state_q <= bst_next(state_q, tms_s);
  end

  assign dec      = bst_decode(ir_q, id_sel_q);
  assign in_shift = (state_q == TAP_SH_DR) || (state_q == TAP_SH_IR);

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction register: capture and shift on rise, update on fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_sr_q  <= BST_IR_BYPASS;
      ir_q     <= BST_IR_BYPASS;
      id_sel_q <= 1'b1;
    end
    else if (state_q == TAP_TLR)
    begin
      ir_q     <= BST_IR_BYPASS;
      id_sel_q <= 1'b1;
    end
    else if (tck_rise && state_q == TAP_CAP_IR)
      ir_sr_q <= BST_IR_CAPTURE;
    else if (tck_rise && state_q == TAP_SH_IR)
      ir_sr_q <= {tdi_s, ir_sr_q[BST_IR_W-1:1]};
    else if (tck_fall && state_q == TAP_UPD_IR)
    begin
      ir_q     <= ir_sr_q;
      id_sel_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bypass and identification data registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byp_q   <= 1'b0;
      id_sr_q <= BST_ID_VALUE;
    end
    else if (tck_rise && state_q == TAP_CAP_DR)
    begin
      byp_q   <= 1'b0;
      id_sr_q <= BST_ID_VALUE;
    end
    else if (tck_rise && state_q == TAP_SH_DR)
    begin
      byp_q   <= tdi_s;
      id_sr_q <= {tdi_s, id_sr_q[BST_ID_W-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Boundary cells: input cell sees the pad, output and enable cells see the core
  always_comb
  begin
    bsr_par_in = '0;
    bsr_in     = '0;
    bsr_out    = '0;
    bsr_oe     = '0;
    for (int i = 0; i < BST_NUM_IO; i++)
    begin
      bsr_par_in[BST_CELLS*i + BST_CELL_IN]  = pad_sync_q[i];
      bsr_par_in[BST_CELLS*i + BST_CELL_OUT] = core_drive.out[i];
      bsr_par_in[BST_CELLS*i + BST_CELL_OE]  = core_drive.oe[i];
      bsr_in[i]  = bsr_par_out[BST_CELLS*i + BST_CELL_IN];
      bsr_out[i] = bsr_par_out[BST_CELLS*i + BST_CELL_OUT];
      bsr_oe[i]  = bsr_par_out[BST_CELLS*i + BST_CELL_OE];
    end
  end

  bst_bsr_chain u_bsr (
    .clk        (clk),
    .rst_n      (rst_n),
    .capture_en (tck_rise && state_q == TAP_CAP_DR && dec.sel_bsr),
    .shift_en   (tck_rise && state_q == TAP_SH_DR && dec.sel_bsr),
    .update_en  (tck_fall && state_q == TAP_UPD_DR && dec.sel_bsr),
    .tdi        (tdi_s),
    .par_in     (bsr_par_in),
    .par_out    (bsr_par_out),
    .so         (bsr_so)
  );

  // Data register feeding the serial output
  assign dr_bit = dec.sel_bsr ? bsr_so : (dec.sel_id ? id_sr_q[0] : byp_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output: moves only at test clock fall, released outside shifting
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (state_q == TAP_TLR)
      tdo_oe_q <= 1'b0;
    else if (tck_fall)
    begin
      tdo_oe_q <= in_shift;
      if (in_shift)
        tdo_q <= (state_q == TAP_SH_IR) ? ir_sr_q[0] : dr_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad and core drive selected by the active instruction
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_q     <= '0;
      core_in_q <= '0;
    end
    else
    begin
      if (dec.hiz)
        pad_q <= '0;
      else if (dec.drive)
      begin
        pad_q.out <= bsr_out;
        pad_q.oe  <= bsr_oe;
      end
      else
        pad_q <= core_drive;
      core_in_q <= dec.core ? bsr_in : pad_sync_q;
    end
  end

  assign tdo       = tdo_q;
  assign tdo_oe    = tdo_oe_q;
  assign pad_drive = pad_q;
  assign core_in   = core_in_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [2:0] tms_ones_q;   // Consecutive rises with mode-select high, saturating
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tms_ones_q <= '0;
    else if (tck_rise)
      tms_ones_q <= !tms_s ? 3'h0 : (tms_ones_q == 3'h5 ? 3'h5 : tms_ones_q + 3'h1);
  end

  sequence s_ir_update;
    tck_fall && state_q == TAP_UPD_IR;
  endsequence

  sequence s_dr_shift_rise;
    tck_rise && state_q == TAP_SH_DR && !dec.sel_bsr && !dec.sel_id;
  endsequence

  chk_five_ones_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (tms_ones_q == 3'h5) |-> state_q == TAP_TLR)
    else $error("five high mode-select rises did not reach reset state");

  chk_tlr_leave_rti: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_q == TAP_TLR && !tms_s) |=> state_q == TAP_RTI)
    else $error("low mode-select did not leave reset state");

  chk_state_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tck_rise |=> $stable(state_q))
    else $error("controller moved without a test clock rise");

  chk_ir_reset_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == TAP_TLR |=> ir_q == BST_IR_BYPASS && id_sel_q)
    else $error("reset state did not load bypass code");

  chk_ir_update_load: assert property (@(posedge clk) disable iff (!rst_n)
    s_ir_update |=> ir_q == $past(ir_sr_q))
    else $error("instruction not loaded at update");

  chk_bypass_path: assert property (@(posedge clk) disable iff (!rst_n)
    s_dr_shift_rise |=> byp_q == $past(tdi_s))
    else $error("bypass bit did not take serial input");

  chk_tdo_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(tdo_q) |-> $past(tck_fall) && $past(in_shift))
    else $error("serial output changed away from a falling test clock edge");

  chk_tdo_released: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && !in_shift) |=> !tdo_oe_q)
    else $error("serial output driven outside shifting");

  chk_highz_pins: assert property (@(posedge clk) disable iff (!rst_n)
    (ir_q == BST_IR_HIGHZ) [*2] |-> pad_q.oe == '0)
    else $error("pins not released under high impedance code");

  chk_clamp_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (ir_q == BST_IR_CLAMP) |=> pad_q.out == $past(bsr_out) && pad_q.oe == $past(bsr_oe))
    else $error("pins not held from boundary register");

  chk_id_low_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_q == TAP_CAP_DR) |=> id_sr_q[0] == 1'b1)
    else $error("identification lowest bit not one");

endmodule : bst_tap

// ### bst_tester.sv
// Test-port tester model: drives test clock, mode-select and serial input
`timescale 1ns/1ps
module bst_tester
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_w
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels: test clock parked low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One 125 ns test clock period; inputs change in the low phase, output read before the rise
  task automatic tick(input logic m, input logic d, output logic s);
    tms = m;
    tdi = d;
    #62.5;
    s   = tdo_w;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask : tick

  // Full scan from run-test-idle back to run-test-idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic s;
    dout = 32'h0000_0000;
    tick(1'b1, 1'b0, s);
    if (ir)
      tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
    tick(1'b0, 1'b0, s);
    for (int k = 0; k < n; k++)
    begin
      tick(k == n - 1, din[k], s);
      dout[k] = s;
    end
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : scan

  // Five rises with mode-select high, then park in run-test-idle
  task automatic reset5();
    logic s;
    repeat (5) tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : reset5

endmodule : bst_tester

// ### bst_tap_test.sv
// Self-checking testbench of the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_test;
  import bst_pkg::*;

  typedef struct packed {
    logic [2:0] ir;
    logic [3:0] len;
    logic [1:0] mode;  // 0 core, 1 boundary drive, 2 released
  } bst_row_t;

  logic                  clk;
  logic                  rst_n;
  logic                  tck;
  logic                  tms;
  logic                  tdi;
  logic                  tdo;
  logic                  tdo_oe;
  wire logic             tdo_w;
  bst_pins_t             core_drive;
  logic [BST_NUM_IO-1:0] pad_in;
  bst_pins_t             pad_drive;
  logic [BST_NUM_IO-1:0] core_in;
  int                    num_errors;
  int                    tests_run;
  logic [31:0]           o;
  logic [15:0]           w;
  logic [11:0]           ub;
  logic                  s;
  bst_row_t              row;
  bst_row_t              rows [8] = '{
    '{BST_IR_EXTEST, 4'hc, 2'h1}, '{BST_IR_SAMPLE, 4'hc, 2'h0},
    '{BST_IR_CLAMP, 4'h1, 2'h1}, '{BST_IR_HIGHZ, 4'h1, 2'h2},
    '{3'h2, 4'h1, 2'h0}, '{3'h3, 4'h1, 2'h0},
    '{3'h4, 4'h1, 2'h0}, '{BST_IR_BYPASS, 4'h1, 2'h0}};

  assign tdo_w = tdo_oe ? tdo : 1'bz;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and tester
  bst_tap u_bst_tap (
    .clk        (clk),
    .rst_n      (rst_n),
    .tck        (tck),
    .tms        (tms),
    .tdi        (tdi),
    .tdo        (tdo),
    .tdo_oe     (tdo_oe),
    .core_drive (core_drive),
    .pad_in     (pad_in),
    .pad_drive  (pad_drive),
    .core_in    (core_in)
  );

  bst_tester u_bst_tester (
    .tck   (tck),
    .tms   (tms),
    .tdi   (tdi),
    .tdo_w (tdo_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and pin expectation helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // Pins taken from the boundary update stage
  function automatic bst_pins_t drv(input logic [11:0] u);
    bst_pins_t p;
    for (int i = 0; i < BST_NUM_IO; i++)
    begin
      p.out[i] = u[3*i+BST_CELL_OUT];
      p.oe[i]  = u[3*i+BST_CELL_OE];
    end
    return p;
  endfunction : drv

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    num_errors = 0;
    tests_run  = 0;
    rst_n      = 1'b0;
    core_drive = 8'ha5;
    pad_in     = 4'h9;
    ub         = 12'h000;
    repeat (8) @(posedge clk);
    #1;
    check({tdo_oe, pad_drive, core_in}, 32'h0000_0000);
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    u_bst_tester.tick(1'b0, 1'b0, s);
    u_bst_tester.scan(1'b0, 32, 32'h0000_0000, o);
    check(o, BST_ID_VALUE);
    // Every instruction code: capture pattern, path length, pins
    for (int r = 0; r < 8; r++)
    begin
      row = rows[r];
      w = 16'h5a3c + 16'h1111 * r[15:0];
      u_bst_tester.scan(1'b1, 3, {29'h0, row.ir}, o);
      check(o[2:0], BST_IR_CAPTURE);
      u_bst_tester.scan(1'b0, 16, {16'h0000, w}, o);
      check(o >> row.len, {16'h0, w} & (32'hffff >> row.len));
      if (row.len == 4'hc)
      begin
        for (int i = 0; i < BST_NUM_IO; i++)
        begin
          check(o[3*i+BST_CELL_IN], pad_in[i]);
          if (row.ir == BST_IR_SAMPLE)
          begin
            check(o[3*i+BST_CELL_OUT], core_drive.out[i]);
            check(o[3*i+BST_CELL_OE], core_drive.oe[i]);
          end
        end
        ub = w[15:4];
      end
      if (row.mode == 2'h2)
        check(pad_drive.oe, 4'h0);
      else if (row.mode == 2'h1)
        check(pad_drive, drv(ub));
      else
        check(pad_drive, core_drive);
      if (row.ir == BST_IR_EXTEST)
        check(core_in, {ub[9], ub[6], ub[3], ub[0]});
      else if (row.mode == 2'h0)
        check(core_in, pad_in);
      check(tdo_oe, 1'b0);
    end
    // Clamp, then forced reset from inside a data shift
    u_bst_tester.scan(1'b1, 3, {29'h0, BST_IR_CLAMP}, o);
    check(pad_drive, drv(ub));
    u_bst_tester.tick(1'b1, 1'b0, s);
    u_bst_tester.tick(1'b0, 1'b0, s);
    u_bst_tester.tick(1'b0, 1'b0, s);
    u_bst_tester.reset5();
    check(pad_drive, core_drive);
    check(tdo_oe, 1'b0);
    u_bst_tester.scan(1'b0, 32, 32'h0000_0000, o);
    check(o, BST_ID_VALUE);
    // Reset in mid-run with clamp loaded, then identification again
    u_bst_tester.scan(1'b1, 3, {29'h0, BST_IR_CLAMP}, o);
    check(pad_drive, drv(ub));
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({tdo_oe, pad_drive, core_in}, 32'h0000_0000);
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(pad_drive, core_drive);
    u_bst_tester.tick(1'b0, 1'b0, s);
    u_bst_tester.scan(1'b0, 32, 32'h0000_0000, o);
    check(o, BST_ID_VALUE);
    summarize();
  end

endmodule : bst_tap_test
